//--- cpq_pkg.sv
/*
  Constants for the codec parameter query block: command and response
  layout, verb and parameter codes, node table layout and link timing.
  Assumes a single core clock that oversamples the link bit clock.
*/
package cpq_pkg;
  localparam int CMD_W  = 40;
  localparam int RSP_W  = 36;
  localparam int DATA_W = 32;

  // Command fields
  localparam int CMD_ADDR_HI = 31;
  localparam int CMD_ADDR_LO = 28;
  localparam int CMD_NODE_HI = 27;
  localparam int CMD_NODE_LO = 20;
  localparam int CMD_VERB_HI = 19;
  localparam int CMD_VERB_LO = 8;
  localparam int CMD_PAY_HI  = 7;
  localparam int CMD_PAY_LO  = 0;

  // Response fields
  localparam int RSP_VALID_BIT = 35;
  localparam int RSP_UNSOL_BIT = 34;

  localparam logic [11:0] VERB_GET_PARAM = 12'hF00;

  // Parameter identifiers
  localparam logic [7:0] PID_IDENTITY   = 8'h00;
  localparam logic [7:0] PID_FG_CAPS    = 8'h08;
  localparam logic [7:0] PID_NODE_CAPS  = 8'h09;
  localparam logic [7:0] PID_SIZE_RATE  = 8'h0A;
  localparam logic [7:0] PID_STREAM_FMT = 8'h0B;
  localparam logic [7:0] PID_PIN_CAPS   = 8'h0C;
  localparam logic [7:0] PID_IN_AMP     = 8'h0D;
  localparam logic [7:0] PID_CONN_LEN   = 8'h0E;
  localparam logic [7:0] PID_OUT_AMP    = 8'h12;

  // Node capability field positions
  localparam int NC_TYPE_LO   = 20;
  localparam int NC_DELAY_LO  = 16;
  localparam int NC_POWER     = 10;
  localparam int NC_DIGITAL   = 9;
  localparam int NC_HAS_LIST  = 8;
  localparam int NC_UNSOL     = 7;
  localparam int NC_PROC      = 6;
  localparam int NC_FMT_OVR   = 4;
  localparam int NC_AMP_OVR   = 3;
  localparam int NC_OUT_AMP   = 2;
  localparam int NC_IN_AMP    = 1;
  localparam int NC_STEREO    = 0;

  typedef enum logic [3:0] {
    CPQ_NT_OUT_CONV = 4'h0,
    CPQ_NT_IN_CONV  = 4'h1,
    CPQ_NT_MIXER    = 4'h2,
    CPQ_NT_SELECTOR = 4'h3,
    CPQ_NT_PIN      = 4'h4,
    CPQ_NT_POWER    = 4'h5,
    CPQ_NT_KNOB     = 4'h6,
    CPQ_NT_VENDOR   = 4'hF
  } cpq_node_type_type;

  localparam logic [7:0] NODE_ROOT = 8'h00;
  localparam logic [7:0] NODE_FG   = 8'h01;
  localparam int         NODE_CNT  = 8;   // Widget nodes 02h..09h
  localparam logic [7:0] NODE_FIRST_WIDGET = 8'h02;

  // Arbitrary identity values, not tied to any real part
  localparam logic [15:0] MAKER_CODE = 16'h1234;
  localparam logic [15:0] PART_CODE  = 16'h0001;

  // Function group defaults
  localparam logic [31:0] FG_CAPS_VAL    = 32'h0001_0000;
  localparam logic [31:0] FG_SIZE_RATE   = 32'h000E_0560;
  localparam logic [31:0] FG_STREAM_FMT  = 32'h0000_0001;
  localparam logic [31:0] FG_IN_AMP      = 32'h8003_1F00;
  localparam logic [31:0] FG_OUT_AMP     = 32'h8005_1F1F;

  // Frame timing: a frame is this many link bit clocks
  localparam int FRAME_BITS = 500;
  localparam int FRAME_CNT_W = 9;
endpackage

//--- cpq_node_table.sv
/*
  Fixed capability table for the widget nodes: one answer per node and
  parameter, chosen purely combinationally. Assumes node and parameter
  codes are already decoded by the caller.
*/
`timescale 1ns/1ns
`default_nettype none
module cpq_node_table
  import cpq_pkg::*;
(
  input  wire logic [7:0]  i_node,
  input  wire logic [7:0]  i_param,
  output logic             o_known,
  output logic [31:0]      o_value
);
  import cpq_pkg::*;

  // Node capability word builder
  function automatic logic [31:0] caps(input cpq_node_type_type t,
                                       input logic [10:0] flags);
    caps = {8'h00, t, 4'h0, 5'h00, flags};
  endfunction

  logic [31:0] nc_r [NODE_CNT];
  logic [31:0] pin_r [NODE_CNT];
  logic [31:0] conn_r [NODE_CNT];
  logic [31:0] fmt_sr_r [NODE_CNT];
  logic [31:0] fmt_sf_r [NODE_CNT];
  logic [31:0] amp_i_r [NODE_CNT];
  logic [31:0] amp_o_r [NODE_CNT];

  // R07 R08 R09 R10 node type and flag layout
  always_comb begin
    nc_r[0] = caps(CPQ_NT_OUT_CONV, 11'h41D);
    nc_r[1] = caps(CPQ_NT_OUT_CONV, 11'h405);
    nc_r[2] = caps(CPQ_NT_IN_CONV,  11'h50B);
    nc_r[3] = caps(CPQ_NT_IN_CONV,  11'h611);
    nc_r[4] = caps(CPQ_NT_MIXER,    11'h103);
    nc_r[5] = caps(CPQ_NT_SELECTOR, 11'h105);
    nc_r[6] = caps(CPQ_NT_PIN,      11'h587);
    nc_r[7] = caps(CPQ_NT_PIN,      11'h4C1);
  end

  // R15 R16 pin answers only for pin complexes
  always_comb begin
    for (int k = 0; k < NODE_CNT; k++) begin
      pin_r[k] = 32'h0000_0000;
    end
    pin_r[6] = 32'h0000_3735;
    pin_r[7] = 32'h0000_0025;
  end

  // R20 R25 short form, input count
  always_comb begin
    for (int k = 0; k < NODE_CNT; k++) begin
      conn_r[k] = 32'h0000_0000;
    end
    conn_r[2] = 32'h0000_0001;
    conn_r[3] = 32'h0000_0001;
    conn_r[4] = 32'h0000_0005;
    conn_r[5] = 32'h0000_0002;
    conn_r[6] = 32'h0000_0002;
    conn_r[7] = 32'h0000_0001;
  end

  // R13 R14 per-converter format answers
  always_comb begin
    for (int k = 0; k < NODE_CNT; k++) begin
      fmt_sr_r[k] = 32'h0000_0000;
      fmt_sf_r[k] = 32'h0000_0000;
      amp_i_r[k]  = 32'h0000_0000;
      amp_o_r[k]  = 32'h0000_0000;
    end
    // R11 R12 size and rate flags
    fmt_sr_r[0] = 32'h001E_07E0;
    fmt_sf_r[0] = 32'h0000_0007;
    fmt_sr_r[3] = 32'h0002_0060;
    fmt_sf_r[3] = 32'h0000_0005;
    // R17 R18 converter own amplifier ranges
    amp_i_r[2]  = 32'h8003_2710;
  end

  logic [2:0] idx;
  logic       in_range;
  logic       is_conv;
  logic [31:0] nc;

  always_comb begin
    in_range = (i_node >= NODE_FIRST_WIDGET)
               && (i_node < NODE_FIRST_WIDGET + 8'(NODE_CNT));
    idx      = 3'(i_node - NODE_FIRST_WIDGET);
    nc       = nc_r[idx];
    is_conv  = (nc[23:20] == CPQ_NT_OUT_CONV) || (nc[23:20] == CPQ_NT_IN_CONV);
    o_known  = 1'b0;
    o_value  = 32'h0000_0000;
    if (in_range) begin
      case (i_param)
        PID_NODE_CAPS: begin
          o_known = 1'b1;
          o_value = nc;
        end
        PID_PIN_CAPS: begin
          o_known = (nc[23:20] == CPQ_NT_PIN);
          o_value = pin_r[idx];
        end
        PID_CONN_LEN: begin
          o_known = 1'b1;
          o_value = conn_r[idx];
        end
        // R13 override else function defaults
        PID_SIZE_RATE: begin
          o_known = is_conv;
          o_value = nc[NC_FMT_OVR] ? fmt_sr_r[idx] : FG_SIZE_RATE;
        end
        PID_STREAM_FMT: begin
          o_known = is_conv;
          o_value = nc[NC_FMT_OVR] ? fmt_sf_r[idx] : FG_STREAM_FMT;
        end
        // R19 amp override else defaults
        PID_IN_AMP: begin
          o_known = nc[NC_IN_AMP];
          o_value = nc[NC_AMP_OVR] ? amp_i_r[idx] : FG_IN_AMP;
        end
        PID_OUT_AMP: begin
          o_known = nc[NC_OUT_AMP];
          o_value = nc[NC_AMP_OVR] ? amp_o_r[idx] : FG_OUT_AMP;
        end
        default: begin
          o_known = 1'b0;
          o_value = 32'h0000_0000;
        end
      endcase
    end
    if (!o_known) begin
      o_value = 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

//--- cpq_query.sv
/*
  Codec parameter query: takes a 40-bit command captured from the link,
  decodes the get-parameter verb and returns the solicited response one
  frame later as a 36-bit word on the serial response line.
  Assumes the link bit clock, frame sync and command line arrive from
  another domain and are oversampled by i_clock; the command word and
  frame boundaries are recovered here.
*/
// Behaviour
// R01 - Unsupported verb answers all zeros
// R02 - Query fields: address, node, F00h, identifier
// R03 - Unknown parameter answers all zeros
// R04 - Parameters read-only, never changed
// R05 - Root parameter 00h gives maker, part codes
// R06 - Function group 08h: tone, delays
// R07 - Node caps type field bits 23:20
// R08 - Node caps delay field, reserved zeros
// R09 - Node caps bits 10..6 meanings
// R10 - Node caps bits 4..0 meanings
// R11 - Sample size flags bits 20..16
// R12 - Sample rate flags bits 11..0
// R13 - Converter override replaces function format defaults
// R14 - Stream format: AC3, float, PCM bits
// R15 - Pin reference voltage options bits 15:8
// R16 - Pin caps only from pin complexes
// R17 - Amp caps mute, step, count, offset
// R18 - Step size quarter decibel, zero fixed
// R19 - Input amp 0Dh, output amp 12h
// R20 - Connection length upper bits zero
// R21 - Decode 0Ah, 0Bh, 0Ch identifiers too
// R22 - Answer sent in following frame
// R23 - 36-bit response: valid, solicited, reserved
// R24 - Host sends 40-bit command layout
// R25 - Connection length: form bit, input count
// R26 - Ignore commands for other codec address
// R27 - Constant answers chosen combinationally
`timescale 1ns/1ns
`default_nettype none
module cpq_query
  import cpq_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic       i_link_clk,
  input  wire logic       i_frame_sync,
  input  wire logic       i_cmd_line,
  input  wire logic [3:0] i_codec_addr,
  output logic            o_resp_line,
  output logic            o_resp_oe_n,
  output logic [31:0]     o_last_resp,
  output logic            o_resp_sent
);
  import cpq_pkg::*;

  typedef enum logic [1:0] {
    CPQ_IDLE  = 2'b00,
    CPQ_HOLD  = 2'b01,
    CPQ_SEND  = 2'b11
  } cpq_state_type;

  // Three-stage samplers; decisions use stages two and three only
  logic [2:0] clk_s_r;
  logic [2:0] sync_s_r;
  logic [2:0] cmd_s_r;
  logic       clk_lvl_r;
  logic       sync_lvl_r;
  logic       cmd_lvl_r;

  // Link clock stages
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      clk_s_r <= 3'h0;
    end else begin
      clk_s_r <= {clk_s_r[1:0], i_link_clk};
    end
  end

  // Frame sync stages
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sync_s_r <= 3'h0;
    end else begin
      sync_s_r <= {sync_s_r[1:0], i_frame_sync};
    end
  end

  // Command line stages
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cmd_s_r <= 3'h0;
    end else begin
      cmd_s_r <= {cmd_s_r[1:0], i_cmd_line};
    end
  end

  // A change counts once stages two and three agree; costs core
  // cycles, so a link half period must span four or more of them
  function automatic logic settle(input logic [2:0] stages, input logic lvl);
    settle = (stages[1] == stages[2]) ? stages[2] : lvl;
  endfunction

  // Settled link clock
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      clk_lvl_r <= 1'b0;
    end else begin
      clk_lvl_r <= settle(clk_s_r, clk_lvl_r);
    end
  end

  // Settled frame sync
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sync_lvl_r <= 1'b0;
    end else begin
      sync_lvl_r <= settle(sync_s_r, sync_lvl_r);
    end
  end

  // Settled command bit
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cmd_lvl_r <= 1'b0;
    end else begin
      cmd_lvl_r <= settle(cmd_s_r, cmd_lvl_r);
    end
  end

  logic link_rise;
  logic link_fall;
  logic clk_prev_r;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      clk_prev_r <= 1'b0;
    end else begin
      clk_prev_r <= clk_lvl_r;
    end
  end
  assign link_rise = clk_lvl_r & ~clk_prev_r;
  assign link_fall = ~clk_lvl_r & clk_prev_r;

  // Frame start: sync seen high at a rising link edge, then low
  logic sync_prev_r;
  logic frame_start;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sync_prev_r <= 1'b0;
    end else if (link_rise) begin
      sync_prev_r <= sync_lvl_r;
    end
  end
  assign frame_start = link_rise & sync_prev_r & ~sync_lvl_r;

  // Command shift-in, first bit is the most significant
  logic [CMD_W-1:0]       cmd_sh_r;
  logic [FRAME_CNT_W-1:0] bit_cnt_r;
  logic                   cmd_done;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      bit_cnt_r <= '0;
    end else if (frame_start) begin
      bit_cnt_r <= FRAME_CNT_W'(1);
    end else if (link_rise && bit_cnt_r != '0 && bit_cnt_r < FRAME_CNT_W'(FRAME_BITS)) begin
      bit_cnt_r <= bit_cnt_r + FRAME_CNT_W'(1);
    end
  end

  // R24 command arrives most significant first
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cmd_sh_r <= '0;
    end else if (link_rise && (frame_start || (bit_cnt_r != '0
                 && bit_cnt_r < FRAME_CNT_W'(CMD_W)))) begin
      cmd_sh_r <= {cmd_sh_r[CMD_W-2:0], cmd_lvl_r};
    end
  end
  assign cmd_done = link_rise && bit_cnt_r == FRAME_CNT_W'(CMD_W - 1);

  // R02 field split
  logic [3:0]  f_addr;
  logic [7:0]  f_node;
  logic [11:0] f_verb;
  logic [7:0]  f_param;
  logic [CMD_W-1:0] cmd_full;
  assign cmd_full = {cmd_sh_r[CMD_W-2:0], cmd_lvl_r};
  assign f_addr   = cmd_full[CMD_ADDR_HI:CMD_ADDR_LO];
  assign f_node   = cmd_full[CMD_NODE_HI:CMD_NODE_LO];
  assign f_verb   = cmd_full[CMD_VERB_HI:CMD_VERB_LO];
  assign f_param  = cmd_full[CMD_PAY_HI:CMD_PAY_LO];

  // R27 answers picked without state
  logic        w_known;
  logic [31:0] w_value;
  cpq_node_table u_table (
    .i_node  (f_node),
    .i_param (f_param),
    .o_known (w_known),
    .o_value (w_value)
  );

  // Group defaults, also seen by converters without override
  function automatic logic [DATA_W-1:0] fg_answer(input logic [7:0] p);
    case (p)
      PID_FG_CAPS:    fg_answer = FG_CAPS_VAL;
      PID_SIZE_RATE:  fg_answer = FG_SIZE_RATE;
      PID_STREAM_FMT: fg_answer = FG_STREAM_FMT;
      PID_IN_AMP:     fg_answer = FG_IN_AMP;
      PID_OUT_AMP:    fg_answer = FG_OUT_AMP;
      default:        fg_answer = 32'h0000_0000;
    endcase
  endfunction

  logic [31:0] answer;
  always_comb begin
    answer = 32'h0000_0000;
    // R01 verbs other than get-parameter answer all zeros
    if (f_verb == VERB_GET_PARAM) begin
      // R05 R06 R21 fixed root and group answers
      case (f_node)
        NODE_ROOT: begin
          answer = (f_param == PID_IDENTITY) ? {MAKER_CODE, PART_CODE} : 32'h0000_0000;
        end
        NODE_FG: begin
          answer = fg_answer(f_param);
        end
        // R03 unknown parameters read as zero
        default: begin
          answer = w_known ? w_value : 32'h0000_0000;
        end
      endcase
    end
  end

  // R22 R26 latch answer for next frame
  cpq_state_type state_r;
  logic [31:0]   pend_r;
  logic [RSP_W-1:0] out_sh_r;
  logic [5:0]    out_cnt_r;
  logic          last_shift;
  logic          take_cmd;

  // R26 other codec addresses never answered
  assign take_cmd   = state_r == CPQ_IDLE && cmd_done && f_addr == i_codec_addr;
  assign last_shift = state_r == CPQ_SEND && link_rise && out_cnt_r == 6'(RSP_W - 1);

  // Solicited frame: valid set, unsolicited flag clear
  function automatic logic [RSP_W-1:0] resp_word(input logic [DATA_W-1:0] a);
    resp_word                = '0;
    resp_word[RSP_VALID_BIT] = 1'b1;
    resp_word[RSP_UNSOL_BIT] = 1'b0;
    resp_word[DATA_W-1:0]    = a;
  endfunction

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_r <= CPQ_IDLE;
    end else begin
      case (state_r)
        CPQ_IDLE: begin
          if (take_cmd) begin
            state_r <= CPQ_HOLD;
          end
        end
        CPQ_HOLD: begin
          if (frame_start) begin
            state_r <= CPQ_SEND;
          end
        end
        CPQ_SEND: begin
          if (last_shift) begin
            state_r <= CPQ_IDLE;
          end
        end
        default: begin
          state_r <= CPQ_IDLE;
        end
      endcase
    end
  end

  // R04 pending copy only, tables never written
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pend_r <= 32'h0000_0000;
    end else if (take_cmd) begin
      pend_r <= answer;
    end
  end

  // R23 valid, solicited, reserved, answer
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      out_sh_r <= '0;
    end else if (state_r == CPQ_HOLD && frame_start) begin
      out_sh_r <= resp_word(pend_r);
    end else if (state_r == CPQ_SEND && link_rise) begin
      out_sh_r <= {out_sh_r[RSP_W-2:0], 1'b0};
    end
  end

  // Response bit counter
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      out_cnt_r <= 6'h00;
    end else if (state_r == CPQ_HOLD && frame_start) begin
      out_cnt_r <= 6'h00;
    end else if (state_r == CPQ_SEND && link_rise) begin
      out_cnt_r <= out_cnt_r + 6'h01;
    end
  end

  // Driven on falling edge so host samples a settled bit
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_resp_line <= 1'b0;
      o_resp_oe_n <= 1'b1;
    end else if (link_fall) begin
      o_resp_line <= (state_r == CPQ_SEND) ? out_sh_r[RSP_W-1] : 1'b0;
      o_resp_oe_n <= (state_r != CPQ_SEND);
    end
  end

  // R22 answer shown from frame start
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_last_resp <= 32'h0000_0000;
    end else if (state_r == CPQ_HOLD && frame_start) begin
      o_last_resp <= pend_r;
    end
  end

  // Pulses as the last bit shifts, before the line is released
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_resp_sent <= 1'b0;
    end else begin
      o_resp_sent <= last_shift;
    end
  end
endmodule
`default_nettype wire

//--- cpq_query_checker.sv
/*
  Checker for the parameter query block: response framing and timing.
  Assumes eight core clocks per link bit, as the bench provides.
*/
`timescale 1ns/1ns
`default_nettype none
module cpq_query_checker (
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic        o_resp_line,
  input wire logic        o_resp_oe_n,
  input wire logic [31:0] o_last_resp,
  input wire logic        o_resp_sent
);
  logic [9:0] low_cnt_r;

  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  // Counted here, a 36-bit window is too long for a repetition
  always_ff @(posedge i_clock) begin
    low_cnt_r <= o_resp_oe_n ? 10'h000 : low_cnt_r + 10'h001;
  end

  rst_quiet_a: assert property (
    disable iff (1'b0) i_rst |=> o_resp_oe_n && !o_resp_sent && !o_resp_line
      && o_last_resp == 32'h0000_0000) else $error("outputs not idle after reset");
  first_valid_a: assert property (
    $fell(o_resp_oe_n) |-> o_resp_line) else $error("first response bit not valid");
  solicited_a: assert property (
    $fell(o_resp_oe_n) |-> ##12 !o_resp_line ##8 !o_resp_line ##8 !o_resp_line)
    else $error("solicited or reserved bits not zero");
  answer_order_a: assert property (
    $fell(o_resp_oe_n) |-> ##36 (o_resp_line == o_last_resp[31])
      ##8 (o_resp_line == o_last_resp[30])) else $error("answer bits out of order");
  drive_len_a: assert property (
    $rose(o_resp_oe_n) |-> low_cnt_r >= 10'h11E && low_cnt_r <= 10'h122)
    else $error("drive window not 36 bits");
  sent_pulse_a: assert property (
    o_resp_sent |=> !o_resp_sent) else $error("sent flag longer than one cycle");
  sent_after_a: assert property (
    o_resp_sent |-> ##[1:8] $rose(o_resp_oe_n))
    else $error("line not released after sent flag");
  hold_answer_a: assert property (
    !o_resp_oe_n |=> $stable(o_last_resp)) else $error("answer changed while sent");
  load_drive_a: assert property (
    $changed(o_last_resp) |-> ##[1:12] $fell(o_resp_oe_n)) else $error("load without drive");

  cover property ($fell(o_resp_oe_n));
  cover property (o_resp_sent && o_last_resp != 32'h0000_0000);
  cover property (o_resp_sent && o_last_resp == 32'h0000_0000);
endmodule
bind cpq_query cpq_query_checker CHK (.i_clock(i_clock), .i_rst(i_rst),
  .o_resp_line(o_resp_line), .o_resp_oe_n(o_resp_oe_n), .o_last_resp(o_last_resp),
  .o_resp_sent(o_resp_sent));
`default_nettype wire

//--- cpq_host_model.sv
/*
  Host link controller model: one frame per call, command out, response in.
  Assumes the caller spaces commands so each answer has its own frame.
*/
`timescale 1ns/1ns
`default_nettype none
module cpq_host_model (
  input  wire logic i_resp_line,
  input  wire logic i_resp_oe_n,
  output logic      o_link_clk,
  output logic      o_frame_sync,
  output logic      o_cmd_line
);
  initial begin
    o_link_clk = 1'b0;
    o_frame_sync = 1'b0;
    o_cmd_line = 1'b0;
  end

  // Short frames keep runs brief; a command and its answer still fit
  localparam int LINK_BITS = 64;

  // Clock stops between frames; line toggles when idle
  task automatic run_frame(input logic [39:0] cmd, output logic [35:0] rsp, output int nb);
    rsp = 36'h0;
    nb = 0;
    for (int b = -1; b < LINK_BITS; b++) begin
      o_link_clk = 1'b0;
      o_frame_sync = (b == -1);
      o_cmd_line = (b >= 0 && b < 40) ? cmd[39 - b] : ~o_cmd_line;
      #16 o_link_clk = 1'b1;
      // Late sample, the answer lags the falling edge
      #15;
      if (i_resp_oe_n === 1'b0) begin
        rsp = {rsp[34:0], i_resp_line};
        nb++;
      end
      #1;
    end
    o_link_clk = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- codec_parameter_query_test.sv
/*
  Self-checking bench for the parameter query block.
  Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ns
`default_nettype none
module codec_parameter_query_test;
  import cpq_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        i_clock;
  logic        i_rst;
  logic        link_clk;
  logic        frame_sync;
  logic        cmd_line;
  logic        resp_line;
  logic        resp_oe_n;
  logic        resp_sent;
  logic [3:0]  codec_addr;
  logic [31:0] last_resp;
  logic [7:0]  rnd;
  logic [63:0] exp_q[$];
  int          err_total;
  int          total_checks;

  always #2 i_clock = ~i_clock;

  cpq_query DUT (.i_clock(i_clock), .i_rst(i_rst), .i_link_clk(link_clk),
    .i_frame_sync(frame_sync), .i_cmd_line(cmd_line), .i_codec_addr(codec_addr),
    .o_resp_line(resp_line), .o_resp_oe_n(resp_oe_n), .o_last_resp(last_resp),
    .o_resp_sent(resp_sent));
  cpq_host_model HOST (.i_resp_line(resp_line), .i_resp_oe_n(resp_oe_n),
    .o_link_clk(link_clk), .o_frame_sync(frame_sync), .o_cmd_line(cmd_line));

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask,
                     input string what);
    total_checks++;
    if ((got & mask) !== (exp & mask)) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Command frame, then a blank frame that carries the answer
  task automatic query(input logic [3:0] addr, input logic [7:0] node, input logic [11:0] verb,
                       input logic [7:0] pay, input logic [31:0] exp, input logic [31:0] mask);
    logic [35:0] rsp;
    int          nb;
    logic        answered;
    answered = (addr == codec_addr);
    rnd = lfsr_next(rnd);
    if (answered) begin
      exp_q.push_back({mask, exp});
    end
    HOST.run_frame({rnd, addr, node, verb, pay}, rsp, nb);
    HOST.run_frame(40'h00_0000_0000, rsp, nb);
    cmp(32'(nb), answered ? 32'h24 : 32'h0, ALL, "bit count");
    if (answered) begin
      cmp({28'h0, rsp[35:32]}, 32'h8, 32'hF, "header");
      cmp(rsp[31:0], exp, mask, "serial answer");
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Each pulse retires the oldest expected answer
  always @(negedge i_clock) begin
    if (resp_sent === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("[ERR] %0t answer sent unasked", $time);
      end else begin
        cmp(last_resp, exp_q[0][31:0], exp_q[0][63:32], "held answer");
        void'(exp_q.pop_front());
      end
    end
  end

  initial begin
    i_clock = 1'b0;
    i_rst = 1'b1;
    codec_addr = 4'h5;
    rnd = 8'h43;
    err_total = 0;
    total_checks = 0;
    repeat (2) @(negedge i_clock);
    i_rst = 1'b0;
    repeat (8) @(negedge i_clock);
    // Odd offset keeps link edges off core edges
    #1;
    query(4'h5, NODE_ROOT, VERB_GET_PARAM, PID_IDENTITY, {MAKER_CODE, PART_CODE}, ALL);
    query(4'h5, NODE_FG, VERB_GET_PARAM, PID_FG_CAPS, FG_CAPS_VAL, ALL);
    query(4'h5, NODE_FG, VERB_GET_PARAM, PID_SIZE_RATE, FG_SIZE_RATE, ALL);
    query(4'h5, NODE_FG, VERB_GET_PARAM, PID_STREAM_FMT, FG_STREAM_FMT, ALL);
    query(4'h5, NODE_FG, VERB_GET_PARAM, PID_IN_AMP, FG_IN_AMP, ALL);
    query(4'h5, NODE_FG, VERB_GET_PARAM, PID_OUT_AMP, FG_OUT_AMP, ALL);
    query(4'h5, NODE_ROOT, 12'h701, rnd, 32'h0, ALL);
    query(4'h5, NODE_ROOT, VERB_GET_PARAM, PID_IDENTITY, {MAKER_CODE, PART_CODE}, ALL);
    query(4'h5, NODE_FG, VERB_GET_PARAM, rnd | 8'h80, 32'h0, ALL);
    query(4'h5, 8'h06, VERB_GET_PARAM, PID_PIN_CAPS, 32'h0, ALL);
    query(4'h5, 8'h08, VERB_GET_PARAM, PID_NODE_CAPS, 32'h0040_0000, 32'hFFF0_F820);
    query(4'h5, 8'h08, VERB_GET_PARAM, PID_PIN_CAPS, 32'h0, 32'hFFFF_C800);
    query(4'h5, 8'h06, VERB_GET_PARAM, PID_CONN_LEN, 32'h0, 32'hFFFF_FF00);
    query(4'h6, NODE_ROOT, VERB_GET_PARAM, PID_IDENTITY, 32'h0, ALL);
    cmp(32'(exp_q.size()), 32'h0, ALL, "answers missing");
    report_and_stop();
  end

  initial begin
    #80000;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
`default_nettype wire
